// ---- rtl/fcs_top.sv ----
// Fast context stack and return-stack fault detection
`timescale 1ns/1ps
module fcs_top
   import fcs_pkg::*;
#(
   parameter int DATA_W = FCS_DATA_W,
   parameter int BANK_W = FCS_BANK_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic vector_event,
   input wire logic fast_call,
   input wire logic fast_return_from_interrupt_instr,
   input wire logic fast_return,
   input wire logic plain_return,
   input wire logic [DATA_W-1:0] status_live,
   input wire logic [DATA_W-1:0] working_register_live,
   input wire logic [BANK_W-1:0] bank_select_register_live,
   output logic restore_valid,
   output logic [DATA_W-1:0] status_restore,
   output logic [DATA_W-1:0] working_register_restore,
   output logic [BANK_W-1:0] bank_select_register_restore,
   input wire logic stack_error_reset_enable,
   input wire logic stack_full_event,
   input wire logic stack_underflow_event,
   input wire logic clear_full,
   input wire logic clear_underflow,
   output logic stack_full_flag,
   output logic stack_underflow_flag,
   output logic device_reset_req
);
   initial begin
      if (DATA_W != 8) begin
         $error("fcs_top data width must be 8");
      end
      if (BANK_W < 1 || BANK_W > 8) begin
         $error("fcs_top bank width unsupported");
      end
   end

   logic [DATA_W-1:0] status_held;
   logic [DATA_W-1:0] work_held;
   logic [BANK_W-1:0] bank_held;
   logic full_next;
   logic unf_next;
   logic reset_pending_reg;

   // Vector and fast call both capture; a nested vector simply overwrites
   wire save_evt = vector_event | fast_call;
   // Plain returns do not restore
   wire restore_evt = fast_return_from_interrupt_instr | fast_return;
   wire fault_evt = stack_full_event | stack_underflow_event;

   fcs_shadow #(.WIDTH(DATA_W), .RST_VAL(FCS_STATUS_RST)) u_status (
      .clk(clk), .rst(rst), .save(save_evt), .live(status_live), .held(status_held));
   fcs_shadow #(.WIDTH(DATA_W), .RST_VAL(FCS_WORK_RST)) u_work (
      .clk(clk), .rst(rst), .save(save_evt), .live(working_register_live), .held(work_held));
   fcs_shadow #(.WIDTH(BANK_W), .RST_VAL(BANK_W'(FCS_BANK_RST))) u_bank (
      .clk(clk), .rst(rst), .save(save_evt), .live(bank_select_register_live),
      .held(bank_held));

   // Restore reads shadow only; shadow is never written on restore
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         restore_valid <= 1'b0;
         status_restore <= FCS_STATUS_RST;
         working_register_restore <= FCS_WORK_RST;
         bank_select_register_restore <= BANK_W'(FCS_BANK_RST);
      end else begin
         restore_valid <= restore_evt;
         if (restore_evt) begin
            status_restore <= status_held;
            working_register_restore <= work_held;
            bank_select_register_restore <= bank_held;
         end
      end
   end

   // Set wins over clear so a fault in the clear cycle is kept
   assign full_next = stack_full_event | (stack_full_flag & ~clear_full);
   assign unf_next = stack_underflow_event | (stack_underflow_flag & ~clear_underflow);

   // Flags are cleared only by clear_full/clear_underflow or power-on reset, never by the reset they request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stack_full_flag <= 1'b0;
         stack_underflow_flag <= 1'b0;
      end else begin
         stack_full_flag <= full_next;
         stack_underflow_flag <= unf_next;
      end
   end

   // Reset follows one cycle after the flag, so the flag is set first
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reset_pending_reg <= 1'b0;
         device_reset_req <= 1'b0;
      end else begin
         reset_pending_reg <= fault_evt & stack_error_reset_enable;
         device_reset_req <= reset_pending_reg;
      end
   end

   a_reset_after_flag: assert property (@(posedge clk) disable iff (rst)
      (fault_evt && stack_error_reset_enable) |-> ##2 device_reset_req)
      else $error("stack fault did not request reset");
   a_no_reset_disabled: assert property (@(posedge clk) disable iff (rst)
      device_reset_req |-> $past(stack_error_reset_enable, 2) && $past(fault_evt, 2))
      else $error("reset requested without enable");
   a_flag_before_reset: assert property (@(posedge clk) disable iff (rst)
      device_reset_req |-> (stack_full_flag || stack_underflow_flag || $past(clear_full)
      || $past(clear_underflow)))
      else $error("reset without flag");
   a_full_sticky: assert property (@(posedge clk) disable iff (rst)
      (stack_full_flag && !clear_full) |=> stack_full_flag)
      else $error("full flag dropped");
   a_unf_sticky: assert property (@(posedge clk) disable iff (rst)
      (stack_underflow_flag && !clear_underflow) |=> stack_underflow_flag)
      else $error("underflow flag dropped");
   a_unf_set: assert property (@(posedge clk) disable iff (rst)
      stack_underflow_event |=> stack_underflow_flag)
      else $error("underflow flag not set");
   a_capture_restore: assert property (@(posedge clk) disable iff (rst)
      (vector_event && !restore_evt) ##1 (!save_evt && restore_evt)
      |=> working_register_restore == $past(working_register_live, 2))
      else $error("shadow round trip failed");
   a_call_status: assert property (@(posedge clk) disable iff (rst)
      fast_call ##1 (!save_evt && fast_return)
      |=> status_restore == $past(status_live, 2))
      else $error("fast call status lost");
   a_plain_no_restore: assert property (@(posedge clk) disable iff (rst)
      (plain_return && !restore_evt) |=> !restore_valid)
      else $error("plain return restored context");
   a_nested_overwrite: assert property (@(posedge clk) disable iff (rst)
      vector_event ##1 (vector_event && !restore_evt) ##1 (!save_evt && restore_evt)
      |=> bank_select_register_restore == $past(bank_select_register_live, 2))
      else $error("nested capture not kept");

   // Flag set, clear and set-wins
   a_full_set: assert property (@(posedge clk) disable iff (rst)
      stack_full_event |=> stack_full_flag)
      else $error("full flag not set");
   a_full_cause: assert property (@(posedge clk) disable iff (rst)
      $rose(stack_full_flag) |-> $past(stack_full_event))
      else $error("full flag set without event");
   a_unf_cause: assert property (@(posedge clk) disable iff (rst)
      $rose(stack_underflow_flag) |-> $past(stack_underflow_event))
      else $error("underflow flag set without event");
   a_full_clear: assert property (@(posedge clk) disable iff (rst)
      (clear_full && !stack_full_event) |=> !stack_full_flag)
      else $error("full flag not cleared");
   a_unf_clear: assert property (@(posedge clk) disable iff (rst)
      (clear_underflow && !stack_underflow_event) |=> !stack_underflow_flag)
      else $error("underflow flag not cleared");
   a_full_set_wins: assert property (@(posedge clk) disable iff (rst)
      (stack_full_event && clear_full) |=> stack_full_flag)
      else $error("full clear beat a new fault");
   a_unf_set_wins: assert property (@(posedge clk) disable iff (rst)
      (stack_underflow_event && clear_underflow) |=> stack_underflow_flag)
      else $error("underflow clear beat a new fault");

   // Reset request timing
   a_reset_one_cycle: assert property (@(posedge clk) disable iff (rst)
      (device_reset_req && !$past(fault_evt && stack_error_reset_enable))
      |=> !device_reset_req)
      else $error("reset request held too long");
   a_full_reset_order: assert property (@(posedge clk) disable iff (rst)
      (stack_full_event && stack_error_reset_enable)
      |=> stack_full_flag ##1 device_reset_req)
      else $error("full fault order wrong");
   a_unf_reset_order: assert property (@(posedge clk) disable iff (rst)
      (stack_underflow_event && stack_error_reset_enable)
      |=> stack_underflow_flag ##1 device_reset_req)
      else $error("underflow fault order wrong");
   a_req_from_pending: assert property (@(posedge clk) disable iff (rst)
      device_reset_req |-> $past(reset_pending_reg))
      else $error("reset request without pending");
   a_pending_cause: assert property (@(posedge clk) disable iff (rst)
      reset_pending_reg |-> $past(fault_evt && stack_error_reset_enable))
      else $error("pending reset without enabled fault");

   // Shadow capture and hold; hold keeps nested and restore cases honest
   a_status_capture: assert property (@(posedge clk) disable iff (rst)
      save_evt |=> status_held == $past(status_live))
      else $error("status not captured");
   a_work_capture: assert property (@(posedge clk) disable iff (rst)
      save_evt |=> work_held == $past(working_register_live))
      else $error("working value not captured");
   a_bank_capture: assert property (@(posedge clk) disable iff (rst)
      save_evt |=> bank_held == $past(bank_select_register_live))
      else $error("bank value not captured");
   a_status_hold: assert property (@(posedge clk) disable iff (rst)
      !save_evt |=> $stable(status_held))
      else $error("status shadow changed without save");
   a_work_keep: assert property (@(posedge clk) disable iff (rst)
      (restore_evt && !save_evt) |=> $stable(work_held))
      else $error("restore altered working shadow");
   a_bank_keep: assert property (@(posedge clk) disable iff (rst)
      (restore_evt && !save_evt) |=> $stable(bank_held))
      else $error("restore altered bank shadow");

   // Restore outputs
   a_restore_pulse: assert property (@(posedge clk) disable iff (rst)
      restore_valid |-> $past(restore_evt))
      else $error("restore valid without fast return");
   a_restore_status: assert property (@(posedge clk) disable iff (rst)
      restore_evt |=> status_restore == $past(status_held))
      else $error("status restore wrong");
   a_restore_work: assert property (@(posedge clk) disable iff (rst)
      restore_evt |=> working_register_restore == $past(work_held))
      else $error("working restore wrong");
   a_restore_bank: assert property (@(posedge clk) disable iff (rst)
      restore_evt |=> bank_select_register_restore == $past(bank_held))
      else $error("bank restore wrong");
   a_restore_quiet: assert property (@(posedge clk) disable iff (rst)
      !restore_evt |=> $stable(status_restore) && $stable(working_register_restore)
      && $stable(bank_select_register_restore))
      else $error("restore outputs moved without fast return");
   a_call_work: assert property (@(posedge clk) disable iff (rst)
      fast_call ##1 (!save_evt && fast_return)
      |=> working_register_restore == $past(working_register_live, 2))
      else $error("fast call working value lost");
endmodule : fcs_top

// ---- rtl/fcs_pkg.sv ----
// Constants for the fast context stack and stack fault unit
// Contract
// - Enable set: flag then device reset
// - Enable clear: flag only, no reset
// - Flags clear only by software or power-on
// - One-deep hidden shadow for status, working, bank
// - Any interrupt vector loads shadow
// - Fast interrupt return restores from shadow
// - High-priority capture overwrites low-priority shadow
// - Fast call saves context to shadow
// - Fast subroutine return restores from shadow
package fcs_pkg;
   localparam int FCS_DATA_W = 8;
   localparam int FCS_BANK_W = 4;
   localparam logic [7:0] FCS_STATUS_RST = 8'h00;
   localparam logic [7:0] FCS_WORK_RST = 8'h00;
   localparam logic [3:0] FCS_BANK_RST = 4'h0;
   localparam int FCS_RST_HOLD = 2;
endpackage : fcs_pkg

// ---- rtl/fcs_shadow.sv ----
// One-deep shadow register for one core register
`timescale 1ns/1ps
module fcs_shadow #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic save,
   input wire logic [WIDTH-1:0] live,
   output logic [WIDTH-1:0] held
);
   initial begin
      if (WIDTH < 1) $error("fcs_shadow width must be positive");
   end
   // Not reachable by software, only by save events and reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         held <= RST_VAL;
      end else if (save) begin
         held <= live;
      end
   end
endmodule : fcs_shadow

// ---- tb/fcs_core.sv ----
// Core register model that takes back fast restores
`timescale 1ns/1ps
module fcs_core (
   input wire logic clk,
   input wire logic rst,
   input wire logic restore_valid,
   input wire logic [19:0] restore_ctx,
   input wire logic [19:0] set_ctx,
   output logic [19:0] live_ctx
);
   // Restore wins over own writes, as the core does
   always_ff @(posedge clk or posedge rst) begin
      if (rst) live_ctx <= 20'h00000;
      else live_ctx <= restore_valid ? restore_ctx : set_ctx;
   end
endmodule : fcs_core

// ---- tb/fcs_top_tb.sv ----
// Self-checking bench for the fast context stack
`timescale 1ns/1ps
module fcs_top_tb;
   import fcs_pkg::*;
   logic clk = 0, rst = 1, ve = 0, fc = 0, fri = 0, fr = 0, pr = 0, rv, ff, uf, dr;
   logic en = 0, fe = 0, ue = 0, cf = 0, cu = 0;
   logic [19:0] sc = 20'h00000, lc, ex;
   logic [7:0] rs, rw;
   logic [3:0] rb, k;
   wire [19:0] rc = {rs, rw, rb};
   int num_errors = 0, n_checks = 0;
   initial forever #4 clk = ~clk;
   fcs_core fcs_core_i (.clk, .rst, .restore_valid(rv), .restore_ctx(rc), .set_ctx(sc),
      .live_ctx(lc));
   fcs_top fcs_top_i (.clk, .rst, .vector_event(ve), .fast_call(fc),
      .fast_return_from_interrupt_instr(fri), .fast_return(fr), .plain_return(pr),
      .status_live(lc[19:12]), .working_register_live(lc[11:4]),
      .bank_select_register_live(lc[3:0]), .restore_valid(rv), .status_restore(rs),
      .working_register_restore(rw), .bank_select_register_restore(rb),
      .stack_error_reset_enable(en), .stack_full_event(fe), .stack_underflow_event(ue),
      .clear_full(cf), .clear_underflow(cu), .stack_full_flag(ff),
      .stack_underflow_flag(uf), .device_reset_req(dr));
   function automatic logic [2:0] flt_exp(input int j, input logic rq);
      return {j[0], !j[0], rq};
   endfunction : flt_exp
   task automatic chk_ctx(input logic [19:0] got, input logic [19:0] want);
      n_checks++;
      if (got !== want) begin
         num_errors++;
         $display("wrong value at %0t: got %h want %h", $time, got, want);
      end
   endtask : chk_ctx
   task automatic chk_flt(input logic [2:0] got, input logic [2:0] want);
      chk_ctx({17'h00000, got}, {17'h00000, want});
   endtask : chk_flt
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : close_out
   // Generous span; the tests need a few microseconds
   initial begin
      #50000;
      num_errors++;
      close_out();
   end
   initial begin
      void'($urandom(32'h312B));
      repeat (3) @(posedge clk);
      rst <= 0;
      #1 chk_ctx(rc, {FCS_STATUS_RST, FCS_WORK_RST, FCS_BANK_RST});
      chk_flt({ff, uf, dr}, 3'b000);
      for (int i = 0; i < 40; i++) begin
         k = 4'($urandom);
         @(posedge clk) sc <= 20'($urandom);
         @(posedge clk) begin
            {ve, fc} <= k[0] ? 2'b10 : 2'b01;
            ex = sc;
            if (k[1]) sc <= 20'($urandom);
         end
         // Back-to-back vector replaces the first capture, whether that came from a vector or a fast call
         if (k[1]) @(posedge clk) begin
            {ve, fc} <= 2'b10;
            ex = sc;
         end
         @(posedge clk) {ve, fc, pr} <= 3'b001;
         @(posedge clk) pr <= 0;
         #1 chk_flt({2'b00, rv}, 3'b000);
         repeat (k[3] ? 2 : 1) begin
            @(posedge clk) {fri, fr} <= k[2] ? 2'b10 : 2'b01;
            @(posedge clk) {fri, fr} <= 2'b00;
            #1 chk_ctx({rv, rc}, {1'b1, ex});
         end
      end
      $display("context save and restore test done");
      for (int j = 0; j < 4; j++) begin
         @(posedge clk) begin
            en <= j[1];
            {fe, ue} <= j[0] ? 2'b10 : 2'b01;
         end
         @(posedge clk) {fe, ue} <= 2'b00;
         #1 chk_flt({ff, uf, dr}, flt_exp(j, 1'b0));
         @(posedge clk) #1 chk_flt({ff, uf, dr}, flt_exp(j, j[1]));
         repeat (3) @(posedge clk);
         #1 chk_flt({ff, uf, dr}, flt_exp(j, 1'b0));
         @(posedge clk) {cf, cu} <= 2'b11;
         @(posedge clk) {cf, cu} <= 2'b00;
         #1 chk_flt({ff, uf, dr}, 3'b000);
      end
      $display("stack fault test done");
      close_out();
   end
endmodule : fcs_top_tb
